// [logic/rssc_pkg.sv]
// constants for the reset, suspend and system control block
`default_nettype none
package rssc_pkg;
   // ==========================================================
   // i/o addresses
   localparam logic [7:0] ADDR_WDT_RESTART = 8'h21;
   localparam logic [7:0] ADDR_RC_WAKE     = 8'h22;
   localparam logic [7:0] ADDR_TIMER_LOW   = 8'h23;
   localparam logic [7:0] ADDR_STATUS_CTRL = 8'hFF;
   // ==========================================================
   // processor_status_control fields and values
   localparam int         SC_RUN      = 0;
   localparam int         SC_SUSPEND  = 3;
   localparam int         SC_POR      = 4;
   localparam int         SC_BUSRST   = 5;
   localparam int         SC_WDR      = 6;
   localparam logic [7:0] SC_POR_VALUE = 8'h19;
   localparam int         RC_PIN      = 0;
   localparam logic [7:0] RC_WAKE_RESET = 8'h01;
   localparam logic [7:0] TIMER_RESET   = 8'h00;
   // ==========================================================
   // clocking and timing
   localparam int CLK_HZ        = 40_000_000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int RESONATOR_HZ  = 6_000_000;
   localparam int TMR_PRESCALE  = 6;
   localparam int US_DIV        = CLK_HZ / (RESONATOR_HZ / TMR_PRESCALE);
   localparam int TICK_FAST_US  = 128;
   localparam int TICK_SLOW_US  = 1024;
   localparam int WDT_BITS      = 4;
   localparam int WDR_HOLD_NS   = 8_192_000;
   localparam int WDR_HOLD_CYC  = WDR_HOLD_NS / CLK_PERIOD_NS;
   localparam int SE0_MIN_NS    = 8_000;
   localparam int SE0_CYC       = (SE0_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_MAX_US   = 256;
   localparam int WAKE_CYC      = (WAKE_MAX_US * 1000) / CLK_PERIOD_NS;
   // ==========================================================
   // power state
   typedef enum logic [1:0] {
      PWR_BOOT,
      PWR_ACTIVE,
      PWR_SUSPEND,
      PWR_SETTLE
   } rssc_pwr_e;
endpackage
`default_nettype wire

// [logic/rssc_tmr_if.sv]
// link between the control logic and the timer/watchdog module
`timescale 1ns/1ps
`default_nettype none
interface rssc_tmr_if;
   logic       halt;
   logic       wdt_clear;
   logic       tick_fast;
   logic       tick_slow;
   logic       wdt_fire;
   logic [7:0] timer_low;
   logic [3:0] wdt_count;
   modport ctl (output halt, output wdt_clear, input tick_fast,
                input tick_slow, input wdt_fire, input timer_low, input wdt_count);
   modport tmr (input halt, input wdt_clear, output tick_fast,
                output tick_slow, output wdt_fire, output timer_low, output wdt_count);
endinterface
`default_nettype wire

// [logic/rssc_timer.sv]
// free-running timer, periodic ticks and watchdog counter
`timescale 1ns/1ps
`default_nettype none
module rssc_timer #(
   parameter int US_DIV = rssc_pkg::US_DIV
) (
   input  wire logic core_clk,
   input  wire logic rst,
   rssc_tmr_if.tmr   tif
);
   import rssc_pkg::*;

   localparam int DIV_W  = (US_DIV > 1) ? $clog2(US_DIV) : 1;
   localparam int FAST_W = $clog2(TICK_FAST_US);
   localparam int SLOW_W = $clog2(TICK_SLOW_US);

   if (US_DIV < 1) begin : g_chk
      $error("rssc_timer: US_DIV must be at least 1");
   end

   logic [DIV_W-1:0]    div_r;
   logic [SLOW_W-1:0]   tmr_r;
   logic [WDT_BITS-1:0] wdt_r;

   // ==========================================================
   // tick decode
   wire us_tick   = (div_r == DIV_W'(US_DIV - 1));
   wire fast_wrap = us_tick && (tmr_r[FAST_W-1:0] == '1);
   wire slow_wrap = us_tick && (tmr_r == '1);
   wire wdt_top   = (wdt_r == {1'b0, {(WDT_BITS-1){1'b1}}});

   assign tif.timer_low = tmr_r[7:0]; // RQ20
   assign tif.wdt_count = wdt_r;

   // ==========================================================
   // counters; all of them stand at zero while suspended
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_r         <= '0;
         tmr_r         <= '0;
         wdt_r         <= '0;
         tif.tick_fast <= 1'b0;
         tif.tick_slow <= 1'b0;
         tif.wdt_fire  <= 1'b0;
      end else if (tif.halt) begin
         div_r         <= '0; // RQ15
         tmr_r         <= '0; // RQ21
         wdt_r         <= '0; // RQ23
         tif.tick_fast <= 1'b0;
         tif.tick_slow <= 1'b0;
         tif.wdt_fire  <= 1'b0;
      end else begin
         div_r <= us_tick ? '0 : div_r + 1'b1; // RQ20
         if (us_tick) begin
            tmr_r <= tmr_r + 1'b1;
         end
         tif.tick_fast <= fast_wrap; // RQ22
         tif.tick_slow <= slow_wrap; // RQ22
         // a restart write beats a tick landing in the same cycle
         if (tif.wdt_clear) begin
            wdt_r <= '0; // RQ10
         end else if (slow_wrap) begin
            wdt_r <= wdt_r + 1'b1; // RQ9
         end
         tif.wdt_fire <= slow_wrap && wdt_top && !tif.wdt_clear; // RQ9
      end
   end

   // ==========================================================
   // checks
   a_halt_clears: assert property (@(posedge core_clk) disable iff (rst) // RQ21
      tif.halt |=> (tmr_r == '0) && (wdt_r == '0))
      else $error("timer or watchdog not cleared while halted");
   a_wdt_restart: assert property (@(posedge core_clk) disable iff (rst) // RQ10
      (tif.wdt_clear && !tif.halt) |=> (wdt_r == '0) && !tif.wdt_fire)
      else $error("watchdog restart did not clear the counter");
   a_wdt_msb_rise: assert property (@(posedge core_clk) disable iff (rst) // RQ9
      (slow_wrap && wdt_top && !tif.wdt_clear && !tif.halt)
      |=> tif.wdt_fire && wdt_r[WDT_BITS-1])
      else $error("watchdog did not fire on msb rise");
   a_tick_nested: assert property (@(posedge core_clk) disable iff (rst) // RQ22
      tif.tick_slow |-> tif.tick_fast ##1 !tif.tick_fast [*2])
      else $error("slow tick not aligned with fast tick");
endmodule // rssc_timer
`default_nettype wire

// [logic/rssc_top.sv]
// reset, suspend and system control: reset causes, run/suspend, watchdog, rc wake pin
// Overview of operation
// RQ1 - any reset restores defaults and pulses the system reset to clear address, irqs, stacks
// RQ2 - firmware writes zeros to status bits 1, 2, 7 and ignores them on read
// RQ3 - status bits 4, 5, 6 record power-on, bus and watchdog reset
// RQ4 - run bit set by power-on; once cleared only a reset sets it again
// RQ5 - after reset fetch starts at zero unless the suspend bit is set
// RQ6 - suspend stops oscillator and timers; usb, gpio or rc wake end it
// RQ7 - power-on loads the status register with 00011001
// RQ8 - after power-on stay suspended until the usb bus leaves idle
// RQ9 - 4-bit watchdog on the 1.024 ms tick resets when its msb rises
// RQ10 - any write to the watchdog restart register clears the watchdog
// RQ11 - watchdog reset holds the processor for 8.192 ms, then fetch from zero
// RQ12 - after watchdog reset usb transmitter stays off until bit 6 is cleared
// RQ13 - se0 lasting 8 us is taken as a usb bus reset
// RQ14 - bus reset in suspend wakes the device but holds the processor until se0 ends
// RQ15 - while suspended the free-running timer and watchdog are stopped
// RQ16 - after wake the processor is running again within 256 us
// RQ17 - after wake one instruction retires before interrupts are serviced
// RQ18 - rc wake pin bit 0 low drives the open-drain pin, high releases; rise wakes
// RQ19 - reading the rc wake register returns the pin; reset releases the pin
// RQ20 - timer counts 1 us steps and its low byte reads at 0x23
// RQ21 - free-running timer cleared by power-on and on suspend entry
// RQ22 - timer gives a 128 us and a 1.024 ms periodic event
// RQ23 - watchdog cleared by every reset and while suspended
`timescale 1ns/1ps
`default_nettype none
module rssc_top #(
   parameter int WDR_HOLD_CYC = rssc_pkg::WDR_HOLD_CYC,
   parameter int WAKE_CYC     = rssc_pkg::WAKE_CYC,
   parameter int SE0_CYC      = rssc_pkg::SE0_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [7:0] io_addr,
   input  wire logic [7:0] io_wdata,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   output logic      [7:0] io_rdata_r,
   input  wire logic       usb_dp_in,
   input  wire logic       usb_dm_in,
   input  wire logic       gpio_wake,
   input  wire logic       instr_retired,
   input  wire logic       rc_wake_in,
   output logic            rc_wake_out_r,
   output logic            rc_wake_oe_r,
   output logic            rc_wake_irq_r,
   output logic            core_reset_r,
   output logic            core_stall_r,
   output logic            irq_hold_r,
   output logic            osc_enable_r,
   output logic            usb_tx_enable_r,
   output logic            sys_reset_r,
   output wire logic       tick_128us,
   output wire logic       tick_1024us
);
   import rssc_pkg::*;

   localparam int WDR_W  = $clog2(WDR_HOLD_CYC + 1);
   localparam int WAKE_W = $clog2(WAKE_CYC + 1);
   localparam int SE0_W  = $clog2(SE0_CYC + 1);

   if (WDR_HOLD_CYC < 1 || WAKE_CYC < 1 || SE0_CYC < 2) begin : g_chk
      $error("rssc_top: hold, wake and se0 counts too small");
   end

   rssc_tmr_if tif ();

   rssc_timer #(
      .US_DIV (US_DIV)
   ) u_timer (
      .core_clk (core_clk),
      .rst      (rst),
      .tif      (tif)
   );

   // ==========================================================
   // pin synchronisers
   logic [1:0]      usb_s1_r;
   logic [1:0]      usb_s2_r;
   logic            rc_s1_r;
   logic            rc_s2_r;
   logic            rc_s3_r;
   // ==========================================================
   // state
   rssc_pwr_e       pwr_r;
   rssc_pwr_e       pwr_nxt;
   logic [SE0_W-1:0]  se0_cnt_r;
   logic              bus_rst_r;
   logic [WDR_W-1:0]  wdr_cnt_r;
   logic [WAKE_W-1:0] wake_cnt_r;
   logic              run_r;
   logic              por_f_r;
   logic              bus_f_r;
   logic              wdr_f_r;
   logic              rc_drive_r;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         usb_s1_r <= 2'h1;
         usb_s2_r <= 2'h1;
         rc_s1_r  <= 1'b1;
         rc_s2_r  <= 1'b1;
         rc_s3_r  <= 1'b1;
      end else begin
         usb_s1_r <= {usb_dp_in, usb_dm_in};
         usb_s2_r <= usb_s1_r;
         rc_s1_r  <= rc_wake_in;
         rc_s2_r  <= rc_s1_r;
         rc_s3_r  <= rc_s2_r;
      end
   end

   // ==========================================================
   // decode; idle (J) on a low-speed bus is dm high, dp low
   wire dp_s      = usb_s2_r[1];
   wire dm_s      = usb_s2_r[0];
   wire se0       = !dp_s && !dm_s;
   wire bus_busy  = !(dm_s && !dp_s);
   wire rc_rise   = rc_s2_r && !rc_s3_r; // RQ18
   wire wdr_hold  = (wdr_cnt_r != '0);
   wire int_rst   = wdr_hold || bus_rst_r;
   wire bus_evt   = se0 && (se0_cnt_r == SE0_W'(SE0_CYC - 1)); // RQ13
   wire int_evt   = tif.wdt_fire || bus_evt;
   wire sleeping  = (pwr_r == PWR_BOOT) || (pwr_r == PWR_SUSPEND);
   wire wake_any  = bus_busy || gpio_wake || rc_rise; // RQ6
   wire wake_done = (wake_cnt_r == WAKE_W'(WAKE_CYC - 1));
   wire wr_ok     = io_wr && !int_rst;
   wire wr_wdt    = wr_ok && (io_addr == ADDR_WDT_RESTART);
   wire wr_rc     = wr_ok && (io_addr == ADDR_RC_WAKE);
   wire wr_sc     = wr_ok && (io_addr == ADDR_STATUS_CTRL);
   wire susp_req  = wr_sc && io_wdata[SC_SUSPEND];

   // reserved status bits read as zero and are dropped on write
   wire [7:0] sc_rd = {1'b0, wdr_f_r, bus_f_r, por_f_r,
                       sleeping, 2'b00, run_r}; // RQ2 RQ3
   wire [7:0] rd_data =
      (io_addr == ADDR_STATUS_CTRL) ? sc_rd :
      (io_addr == ADDR_RC_WAKE)     ? {7'h00, rc_s2_r} : // RQ19
      (io_addr == ADDR_TIMER_LOW)   ? tif.timer_low :   // RQ20
                                      8'h00;

   assign tif.halt      = sleeping; // RQ6 RQ15
   assign tif.wdt_clear = wr_wdt || int_rst; // RQ10 RQ23
   assign tick_128us    = tif.tick_fast; // RQ22
   assign tick_1024us   = tif.tick_slow; // RQ22

   // ==========================================================
   // power state; only bus activity ends the power-on suspend
   always_comb begin
      pwr_nxt = pwr_r;
      unique case (pwr_r)
         PWR_BOOT: begin
            if (bus_busy) begin
               pwr_nxt = PWR_SETTLE; // RQ8
            end
         end
         PWR_SUSPEND: begin
            if (wake_any) begin
               pwr_nxt = PWR_SETTLE; // RQ6 RQ14
            end
         end
         PWR_SETTLE: begin
            if (wake_done) begin
               pwr_nxt = PWR_ACTIVE; // RQ16
            end
         end
         PWR_ACTIVE: begin
            if (susp_req) begin
               pwr_nxt = PWR_SUSPEND; // RQ6
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pwr_r      <= PWR_BOOT; // RQ7 RQ8
         wake_cnt_r <= '0;
      end else begin
         pwr_r      <= pwr_nxt;
         wake_cnt_r <= (pwr_r == PWR_SETTLE) ? wake_cnt_r + 1'b1 : '0; // RQ16
      end
   end

   // ==========================================================
   // bus reset: count se0, hold the level until se0 ends
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         se0_cnt_r <= '0;
         bus_rst_r <= 1'b0;
      end else begin
         if (!se0) begin
            se0_cnt_r <= '0;
         end else if (se0_cnt_r != SE0_W'(SE0_CYC)) begin
            se0_cnt_r <= se0_cnt_r + 1'b1;
         end
         bus_rst_r <= se0 && (bus_evt || bus_rst_r); // RQ13 RQ14
      end
   end

   // ==========================================================
   // watchdog reset hold
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wdr_cnt_r <= '0;
      end else if (tif.wdt_fire) begin
         wdr_cnt_r <= WDR_W'(WDR_HOLD_CYC); // RQ11
      end else if (wdr_hold) begin
         wdr_cnt_r <= wdr_cnt_r - 1'b1;
      end
   end

   // ==========================================================
   // status flags: a hardware set wins over a firmware clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         run_r   <= SC_POR_VALUE[SC_RUN]; // RQ4 RQ7
         por_f_r <= SC_POR_VALUE[SC_POR]; // RQ3 RQ7
         bus_f_r <= SC_POR_VALUE[SC_BUSRST];
         wdr_f_r <= SC_POR_VALUE[SC_WDR];
      end else begin
         if (int_evt) begin
            run_r <= 1'b1; // RQ4
         end else if (wr_sc) begin
            run_r <= run_r && io_wdata[SC_RUN]; // RQ4
         end
         if (wr_sc) begin
            por_f_r <= io_wdata[SC_POR];
         end
         bus_f_r <= bus_evt || (wr_sc ? io_wdata[SC_BUSRST] : bus_f_r); // RQ3
         wdr_f_r <= tif.wdt_fire || (wr_sc ? io_wdata[SC_WDR] : wdr_f_r); // RQ3 RQ12
      end
   end

   // ==========================================================
   // rc wake pin: open drain, released by every reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rc_drive_r    <= 1'b0;
         rc_wake_out_r <= 1'b0;
         rc_wake_oe_r  <= 1'b0;
         rc_wake_irq_r <= 1'b0;
      end else begin
         if (int_rst) begin
            rc_drive_r <= !RC_WAKE_RESET[RC_PIN]; // RQ19
         end else if (wr_rc) begin
            rc_drive_r <= !io_wdata[RC_PIN]; // RQ18
         end
         rc_wake_out_r <= 1'b0;
         rc_wake_oe_r  <= rc_drive_r && !int_rst; // RQ18 RQ19
         rc_wake_irq_r <= rc_rise; // RQ18
      end
   end

   // ==========================================================
   // processor and system controls, all registered
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         io_rdata_r      <= 8'h00;
         core_reset_r    <= 1'b1;
         core_stall_r    <= 1'b1;
         irq_hold_r      <= 1'b0;
         osc_enable_r    <= 1'b0;
         usb_tx_enable_r <= 1'b1;
         sys_reset_r     <= 1'b1; // RQ1
      end else begin
         if (io_rd) begin
            io_rdata_r <= rd_data;
         end
         // release from reset means fetch from address zero
         core_reset_r    <= (pwr_r == PWR_BOOT) || int_rst; // RQ5 RQ11 RQ14
         core_stall_r    <= (pwr_r != PWR_ACTIVE) || !run_r; // RQ4 RQ6
         osc_enable_r    <= !sleeping; // RQ6 RQ14
         usb_tx_enable_r <= !wdr_f_r; // RQ12
         sys_reset_r     <= int_rst; // RQ1
         // first instruction after a firmware wake runs before interrupts
         if (pwr_r == PWR_SUSPEND && wake_any) begin
            irq_hold_r <= 1'b1; // RQ17
         end else if (instr_retired && pwr_r == PWR_ACTIVE) begin
            irq_hold_r <= 1'b0; // RQ17
         end
      end
   end

   // ==========================================================
   // checks
   a_run_stays_low: assert property (@(posedge core_clk) disable iff (rst) // RQ4
      (!run_r && !int_evt) |=> !run_r)
      else $error("run bit rose without a reset");
   a_wdr_flag_set: assert property (@(posedge core_clk) disable iff (rst) // RQ3
      tif.wdt_fire |=> wdr_f_r && (wdr_cnt_r == WDR_W'(WDR_HOLD_CYC)))
      else $error("watchdog reset not recorded or hold not loaded");
   a_wdr_hold_core: assert property (@(posedge core_clk) disable iff (rst) // RQ11
      tif.wdt_fire |-> ##2 core_reset_r && sys_reset_r)
      else $error("processor not held after watchdog reset");
   a_usb_tx_off: assert property (@(posedge core_clk) disable iff (rst) // RQ12
      wdr_f_r |=> !usb_tx_enable_r)
      else $error("transmitter enabled while watchdog flag set");
   a_bus_reset_seen: assert property (@(posedge core_clk) disable iff (rst) // RQ13
      bus_evt |=> bus_rst_r && bus_f_r ##1 (core_reset_r || !se0))
      else $error("se0 of the minimum length not taken as bus reset");
   a_bus_reset_wake: assert property (@(posedge core_clk) disable iff (rst) // RQ14
      (pwr_r == PWR_SUSPEND && se0) |=> (pwr_r == PWR_SETTLE) ##1 osc_enable_r)
      else $error("bus reset did not end suspend");
   a_suspend_stops: assert property (@(posedge core_clk) disable iff (rst) // RQ6
      (pwr_r == PWR_SUSPEND) |=> !osc_enable_r && core_stall_r)
      else $error("oscillator or processor running while suspended");
   a_wake_bound: assert property (@(posedge core_clk) disable iff (rst) // RQ16
      (pwr_r == PWR_SETTLE && wake_done) |=> (pwr_r == PWR_ACTIVE))
      else $error("wake settle overran its bound");
   a_rc_drive: assert property (@(posedge core_clk) disable iff (rst) // RQ18
      (wr_rc && !io_wdata[RC_PIN]) |-> ##2 rc_wake_oe_r && !rc_wake_out_r)
      else $error("rc wake pin not driven low after write of zero");
   a_boot_held: assert property (@(posedge core_clk) disable iff (rst) // RQ8
      (pwr_r == PWR_BOOT && !bus_busy) |=> (pwr_r == PWR_BOOT) ##1 core_reset_r)
      else $error("left power-on suspend without bus activity");
endmodule // rssc_top
`default_nettype wire

// [test/rssc_usb_host.sv]
// behavioural usb host bus model driving the line levels seen by the block
`timescale 1ns/1ps
`default_nettype none
module rssc_usb_host (
   input  wire logic core_clk,
   output var logic  usb_dp_in,
   output var logic  usb_dm_in
);
   // ==========================================
   // line states
   // bus parks in the idle state (dp low, dm high) between transfers
   initial begin
      usb_dp_in = 1'b0;
      usb_dm_in = 1'b1;
   end
   // non-idle k state for n cycles, then back to idle
   task automatic send_activity(input int n);
      @(negedge core_clk);
      usb_dp_in = 1'b1;
      usb_dm_in = 1'b0;
      repeat (n) @(negedge core_clk);
      usb_dp_in = 1'b0;
      usb_dm_in = 1'b1;
   endtask
   // both lines low for n cycles; caller may inspect before release
   task automatic hold_se0(input int n);
      @(negedge core_clk);
      usb_dp_in = 1'b0;
      usb_dm_in = 1'b0;
      repeat (n) @(negedge core_clk);
   endtask
   // end a bus reset by returning to idle
   task automatic release_se0();
      usb_dm_in = 1'b1;
   endtask
endmodule // rssc_usb_host
`default_nettype wire

// [test/test_reset_suspend_system_control.sv]
// self-checking bench for the reset, suspend and system control block
`timescale 1ns/1ps
`default_nettype none
module test_reset_suspend_system_control;
   import rssc_pkg::*;
   logic       core_clk, rst, io_wr, io_rd, gpio_wake, instr_retired;
   logic [7:0] io_addr, io_wdata, rd;
   wire logic  dp, dm, rc_pin;
   wire logic  [7:0] io_rdata_r;
   wire logic  rc_out, rc_oe, rc_irq, core_reset_r, core_stall_r, irq_hold_r;
   wire logic  osc_en, tx_en, sys_reset_r, t128, t1024;
   int         bad_count, samples_checked, irq_seen, i, t0;
   logic [7:0] first;
   // ==========================================
   // comparison macro
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
   // rc pin: external resistor pulls high unless the open-drain driver sinks it
   assign rc_pin = rc_oe ? 1'b0 : 1'b1;
   // short counts keep the run small
   rssc_top #(.WDR_HOLD_CYC(50), .WAKE_CYC(8), .SE0_CYC(6)) dut (
      .core_clk(core_clk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_wr(io_wr), .io_rd(io_rd), .io_rdata_r(io_rdata_r), .usb_dp_in(dp),
      .usb_dm_in(dm), .gpio_wake(gpio_wake), .instr_retired(instr_retired),
      .rc_wake_in(rc_pin), .rc_wake_out_r(rc_out), .rc_wake_oe_r(rc_oe),
      .rc_wake_irq_r(rc_irq), .core_reset_r(core_reset_r), .core_stall_r(core_stall_r),
      .irq_hold_r(irq_hold_r), .osc_enable_r(osc_en), .usb_tx_enable_r(tx_en),
      .sys_reset_r(sys_reset_r), .tick_128us(t128), .tick_1024us(t1024));
   rssc_usb_host host (.core_clk(core_clk), .usb_dp_in(dp), .usb_dm_in(dm));
   // ==========================================
   // clock, wake pulse counter, watchdog
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // counted mid-cycle so the pulse is seen settled, not at its launching edge
   always @(negedge core_clk) if (rc_irq === 1'b1) irq_seen++;
   initial begin
      repeat (60000) @(posedge core_clk);
      bad_count++;
      wrap_up();
   end
   // ==========================================
   // access tasks, driven on the falling edge
   task automatic io_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge core_clk);
      io_wr = 1'b0;
   endtask
   // read data is registered, so allow an extra edge before sampling
   task automatic io_read(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge core_clk);
      io_rd = 1'b0;
      @(negedge core_clk);
      d = io_rdata_r;
   endtask
   task automatic wait_run(input int lim);
      for (i = 0; i < lim && core_stall_r !== 1'b0; i++) @(negedge core_clk);
   endtask
   task automatic wrap_up();
      if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ==========================================
   // test sequence
   initial begin
      rst = 1'b1; io_wr = 1'b0; io_rd = 1'b0; io_addr = 8'h00; io_wdata = 8'h00;
      gpio_wake = 1'b0; instr_retired = 1'b0; bad_count = 0; samples_checked = 0;
      irq_seen = 0;
      repeat (12) @(negedge core_clk);
      rst = 1'b0;
      // power-on state: suspended with flags 00011001
      io_read(ADDR_STATUS_CTRL, rd); `CHK("status_por", 8'h19, rd)
      io_read(ADDR_RC_WAKE, rd); `CHK("rc_reset", 8'h01, rd)
      io_read(ADDR_TIMER_LOW, rd); `CHK("timer_por", 8'h00, rd)
      io_read(ADDR_WDT_RESTART, rd); `CHK("wdt_read", 8'h00, rd)
      repeat (30) @(negedge core_clk);
      `CHK("core_reset_por", 1'b1, core_reset_r)
      `CHK("osc_off", 1'b0, osc_en)
      `CHK("tx_on", 1'b1, tx_en)
      // only bus activity ends power-on suspend; gpio must not
      gpio_wake = 1'b1;
      @(negedge core_clk);
      gpio_wake = 1'b0;
      repeat (20) @(negedge core_clk);
      `CHK("gpio_no_wake_por", 1'b1, core_stall_r)
      host.send_activity(4);
      wait_run(30);
      `CHK("core_run", 1'b0, core_stall_r)
      `CHK("core_fetch", 1'b0, core_reset_r)
      io_read(ADDR_STATUS_CTRL, rd); `CHK("status_awake", 8'h11, rd)
      // timer runs in 1 us steps: 400 cycles apart gives 10 counts
      io_read(ADDR_TIMER_LOW, first);
      repeat (397) @(negedge core_clk);
      io_read(ADDR_TIMER_LOW, rd); `CHK("timer_step", first + 8'h0A, rd)
      // periodic 128 us event spacing
      while (t128 !== 1'b1) @(negedge core_clk);
      t0 = 0;
      @(negedge core_clk);
      while (t128 !== 1'b1 && t0 < 6000) begin t0++; @(negedge core_clk); end
      `CHK("tick128_gap", 5119, t0)
      // slow event lands on a fast one; the longest wait of the run
      t0 = 0;
      while (t1024 !== 1'b1 && t0 < 45000) begin t0++; @(negedge core_clk); end
      `CHK("tick1024_align", 1'b1, t128)
      io_write(ADDR_WDT_RESTART, 8'hA5);
      // run bit: clear halts, writing 1 back has no effect
      io_write(ADDR_STATUS_CTRL, 8'h00);
      io_write(ADDR_STATUS_CTRL, 8'h01);
      io_read(ADDR_STATUS_CTRL, rd); `CHK("run_stuck_low", 8'h00, rd)
      `CHK("halted", 1'b1, core_stall_r)
      // bus reset holds the core until se0 ends, records the cause, sets run
      host.hold_se0(20);
      `CHK("se0_sys_reset", 1'b1, sys_reset_r)
      `CHK("se0_core_hold", 1'b1, core_reset_r)
      host.release_se0();
      repeat (12) @(negedge core_clk);
      `CHK("se0_released", 1'b0, core_reset_r)
      io_read(ADDR_STATUS_CTRL, rd); `CHK("status_busrst", 8'h21, rd)
      // rc pin: 0 sinks the pin, 1 releases it and the rise raises a wake event
      io_write(ADDR_RC_WAKE, 8'h00);
      // the pin level reaches the register only after the two sync flops
      repeat (4) @(negedge core_clk);
      io_read(ADDR_RC_WAKE, rd); `CHK("rc_low", 8'h00, rd)
      `CHK("rc_drive", 1'b0, rc_out)
      `CHK("rc_sink", 1'b1, rc_oe)
      irq_seen = 0;
      io_write(ADDR_RC_WAKE, 8'h01);
      repeat (6) @(negedge core_clk);
      io_read(ADDR_RC_WAKE, rd); `CHK("rc_high", 8'h01, rd)
      `CHK("rc_irq_count", 1, irq_seen)
      // suspend entry stops oscillator and clears the timer
      io_write(ADDR_STATUS_CTRL, 8'h09);
      repeat (4) @(negedge core_clk);
      `CHK("susp_osc", 1'b0, osc_en)
      `CHK("susp_stall", 1'b1, core_stall_r)
      io_read(ADDR_STATUS_CTRL, rd); `CHK("status_susp", 8'h09, rd)
      repeat (200) @(negedge core_clk);
      io_read(ADDR_TIMER_LOW, rd); `CHK("timer_susp", 8'h00, rd)
      // gpio wake: resume, one instruction before interrupts
      gpio_wake = 1'b1;
      @(negedge core_clk);
      gpio_wake = 1'b0;
      repeat (2) @(negedge core_clk);
      `CHK("wake_osc", 1'b1, osc_en)
      wait_run(20);
      `CHK("wake_run", 1'b0, core_stall_r)
      `CHK("irq_held", 1'b1, irq_hold_r)
      instr_retired = 1'b1;
      @(negedge core_clk);
      instr_retired = 1'b0;
      @(negedge core_clk);
      `CHK("irq_free", 1'b0, irq_hold_r)
      io_read(ADDR_STATUS_CTRL, rd); `CHK("status_woke", 8'h01, rd)
      // rc wake: discharge, suspend, release; the rising pin ends suspend
      io_write(ADDR_RC_WAKE, 8'h00);
      io_write(ADDR_STATUS_CTRL, 8'h09);
      io_write(ADDR_RC_WAKE, 8'h01);
      repeat (6) @(negedge core_clk);
      `CHK("rc_wake_osc", 1'b1, osc_en)
      wait_run(30);
      `CHK("rc_wake_run", 1'b0, core_stall_r)
      // bus reset in suspend wakes at once but holds the core until se0 ends
      io_write(ADDR_STATUS_CTRL, 8'h09);
      host.hold_se0(20);
      `CHK("se0_susp_osc", 1'b1, osc_en)
      `CHK("se0_susp_hold", 1'b1, core_reset_r)
      host.release_se0();
      repeat (6) @(negedge core_clk);
      `CHK("se0_susp_free", 1'b0, core_reset_r)
      io_read(ADDR_STATUS_CTRL, rd); `CHK("status_susp_rst", 8'h21, rd)
      wrap_up();
   end
endmodule // test_reset_suspend_system_control
`default_nettype wire
